//--- rtl/dsoa_pkg.sv
// Constants, types and helpers for the data space and option access block
package dsoa_pkg;

    // SFR addresses owned by this block
    localparam logic [7:0]  XPAGE_SFR    = 8'hF7;
    localparam logic [7:0]  OPT_PTR_SFR  = 8'hFE;
    localparam logic [7:0]  OPT_VAL_SFR  = 8'hFF;
    // Option indices behind the option pointer
    localparam logic [7:0]  OPT_TRIM_IDX = 8'h83;
    localparam logic [7:0]  OPT_BOOT_IDX = 8'hC2;
    // Reset values
    localparam logic [7:0]  OPT_PTR_RST  = 8'h00;
    localparam logic [3:0]  XPAGE_RST    = 4'h0;
    // Internal RAM layout
    localparam logic [7:0]  BIT_AREA_LO  = 8'h20;
    localparam logic [7:0]  UPPER_LO     = 8'h80;
    // External space layout
    localparam logic [15:0] XRAM_HI      = 16'h0FFF;
    localparam logic [15:0] PWM_LO       = 16'h1034;
    localparam logic [15:0] PWM_HI       = 16'h104F;
    // Flash and boot area sizes in bytes
    localparam logic [16:0] FLASH_BYTES  = 17'h08000;
    localparam logic [16:0] BOOT_1K      = 17'h00400;
    localparam logic [16:0] BOOT_2K      = 17'h00800;
    localparam logic [16:0] BOOT_4K      = 17'h01000;
    // Oscillator estimate in units of 0.1 kHz: 32000 kHz, 0.18 % step, 35.2 MHz
    localparam int          FREQ_NOM     = 320000;
    localparam int          FREQ_STEP    = 576;
    localparam int          FREQ_LIMIT   = 352000;

    typedef enum logic [2:0] {
        SPACE_DIRECT, SPACE_INDIRECT, SPACE_BIT, SPACE_WREG, SPACE_XDPTR, SPACE_XRI
    } dsoa_space_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        dsoa_space_t space;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dsoa_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } dsoa_rsp_t;

    // First flash byte of the boot area for a size code
    function automatic logic [16:0] bootBase(input logic [1:0] size);
        case (size)
            2'b01:   bootBase = FLASH_BYTES - BOOT_1K;
            2'b10:   bootBase = FLASH_BYTES - BOOT_2K;
            2'b11:   bootBase = FLASH_BYTES - BOOT_4K;
            default: bootBase = FLASH_BYTES;
        endcase
    endfunction

    // Oscillator frequency estimate for a trim value against the factory value
    function automatic logic [19:0] freqOf(input logic [7:0] trim, input logic [7:0] fac);
        int n;
        n = int'(trim) - int'(fac);
        freqOf = 20'(FREQ_NOM + FREQ_STEP * n);
    endfunction

endpackage

//--- rtl/dsoa_iram.sv
// 256-byte internal RAM with per-bit write mask
`timescale 1ns/1ps
module dsoa_iram #(
    parameter int DEPTH = 256
) (
    input  wire logic       ref_clk,
    input  wire logic       we,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] mask,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    // Masked write keeps untouched bits of the byte
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= (mem[addr] & ~mask) | (wdata & mask);
        end
    end

    // Asynchronous read, registered by the caller
    assign rdata = mem[addr];
endmodule

//--- rtl/dsoa_xram.sv
// External data space: 4 KB RAM plus the PWM duty window
`timescale 1ns/1ps
module dsoa_xram
    import dsoa_pkg::*;
#(
    parameter int XDEPTH = 4096,
    parameter int PDEPTH = 28
) (
    input  wire logic        ref_clk,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] ram [XDEPTH];
    logic [7:0] pwm [PDEPTH];
    logic       inRam;
    logic       inPwm;
    logic [4:0] pIdx;
    logic [15:0] pOff;

    // Window decode; everything else is a hole
    assign inRam = addr <= XRAM_HI;
    assign inPwm = (addr >= PWM_LO) && (addr <= PWM_HI);
    assign pOff  = addr - PWM_LO;
    assign pIdx  = pOff[4:0];

    // Writes outside both windows are dropped
    always_ff @(posedge ref_clk) begin
        if (we && inRam) begin
            ram[addr[11:0]] <= wdata;
        end
        if (we && inPwm) begin
            pwm[pIdx] <= wdata;
        end
    end

    // Holes read as zero
    assign rdata = inRam ? ram[addr[11:0]] : (inPwm ? pwm[pIdx] : 8'h00);
endmodule

//--- rtl/dsoa_core.sv
// Data space decode, option access, trim and boot area control
`timescale 1ns/1ps

//
// Contract
// - Hold a two-bit boot area size field in option space.
// - Code 10 reserves last 2K, code 11 last 4K as boot area.
// - Eight-bit read/write trim register; one step is about 0.18 percent.
// - Frequency equals 32000 kHz times (1 + 0.18 percent times n).
// - Power-on loads trim with the factory value; software may overwrite.
// - Option registers reached via pointer at FEH and value port at FFH.
// - Pointer value 83H selects the trim register.
// - Internal RAM 00H-FFH; upper half only indirectly reachable.
// - Direct 80H-FFH goes to SFRs, indirect goes to upper RAM.
// - 00H-1FH hold four register banks chosen by two status bits.
// - 20H-2FH double as 128 bits, ascending bit by bit.
// - External RAM 0000H-0FFFH only by external-move accesses.
// - External RAM reachable through the 16-bit data pointer.
// - Register-indirect external address is page register then Ri.
// - Page register bits 3-0 hold high address, reset zero.
// - PWM duty registers at 1034H-104FH are read/write.
module dsoa_core
    import dsoa_pkg::*;
#(
    parameter int IRAM_DEPTH = 256,
    parameter int XRAM_DEPTH = 4096,
    parameter int PWM_DEPTH  = 28
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire dsoa_pkg::dsoa_req_t cpuReq,
    input  wire logic [1:0]        bankSelect,
    input  wire logic [7:0]        factoryTrimValue,
    input  wire logic [1:0]        bootSizeStrap,
    output dsoa_pkg::dsoa_rsp_t    cpuRsp_r,
    output logic [7:0]             oscillatorTrim_r,
    output logic [1:0]             bootAreaSize_r,
    output logic [16:0]            bootAreaBase_r,
    output logic [19:0]            oscFreqTenthKhz_r,
    output logic                   trimOverLimit_r,
    output logic                   optionLoaded_r
);
    import dsoa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]  optionPointer_r;
    logic [3:0]  externalRamPage_r;
    logic [7:0]  factoryTrim_r;
    logic        sfrSel;
    logic        iramSel;
    logic        xSel;
    logic [7:0]  iramAddr;
    logic [7:0]  iramMask;
    logic [7:0]  iramWdata;
    logic        iramWe;
    logic [7:0]  iramRdata;
    logic [15:0] xAddr;
    logic        xWe;
    logic [7:0]  xRdata;
    logic [7:0]  sfrRdata;
    logic [7:0]  optRdata;
    logic [7:0]  rdNxt;
    logic        optWrite;

    ////////////////////////////////////////////////////////////////////////
    // Space decode

    // Direct upper half is SFR space, never RAM
    always_comb begin
        sfrSel  = 1'b0;
        iramSel = 1'b0;
        xSel    = 1'b0;
        case (cpuReq.space)
            SPACE_DIRECT: begin
                sfrSel  = cpuReq.addr[7:0] >= UPPER_LO;
                iramSel = cpuReq.addr[7:0] <  UPPER_LO;
            end
            SPACE_INDIRECT: begin
                iramSel = 1'b1;
            end
            SPACE_BIT: begin
                iramSel = !cpuReq.addr[7];
            end
            SPACE_WREG: begin
                iramSel = 1'b1;
            end
            SPACE_XDPTR, SPACE_XRI: begin
                xSel = 1'b1;
            end
            default: begin
                sfrSel = 1'b0;
            end
        endcase
    end

    // Internal RAM address, mask and data per access kind
    always_comb begin
        iramAddr  = cpuReq.addr[7:0];
        iramMask  = 8'hFF;
        iramWdata = cpuReq.wdata;
        case (cpuReq.space)
            SPACE_BIT: begin
                // Bit n lives in byte 20H + n/8, position n mod 8
                iramAddr  = BIT_AREA_LO + {4'h0, cpuReq.addr[6:3]};
                iramMask  = 8'h01 << cpuReq.addr[2:0];
                iramWdata = {8{cpuReq.wdata[0]}};
            end
            SPACE_WREG: begin
                iramAddr = {3'h0, bankSelect, cpuReq.addr[2:0]};
            end
            default: begin
                iramAddr = cpuReq.addr[7:0];
            end
        endcase
    end

    assign iramWe = cpuReq.wr && iramSel;

    // External address: data pointer or page plus working register
    always_comb begin
        if (cpuReq.space == SPACE_XRI) begin
            xAddr = {4'h0, externalRamPage_r, cpuReq.addr[7:0]};
        end else begin
            xAddr = cpuReq.addr;
        end
    end

    assign xWe = cpuReq.wr && xSel;

    ////////////////////////////////////////////////////////////////////////
    // Memories

    dsoa_iram #(
        .DEPTH (IRAM_DEPTH)
    ) uIram (
        .ref_clk (ref_clk),
        .we      (iramWe),
        .addr    (iramAddr),
        .mask    (iramMask),
        .wdata   (iramWdata),
        .rdata   (iramRdata)
    );

    dsoa_xram #(
        .XDEPTH (XRAM_DEPTH),
        .PDEPTH (PWM_DEPTH)
    ) uXram (
        .ref_clk (ref_clk),
        .we      (xWe),
        .addr    (xAddr),
        .wdata   (cpuReq.wdata),
        .rdata   (xRdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // SFR registers

    assign optWrite = cpuReq.wr && sfrSel && cpuReq.addr[7:0] == OPT_VAL_SFR;

    // Option pointer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            optionPointer_r <= OPT_PTR_RST;
        end else if (cpuReq.wr && sfrSel && cpuReq.addr[7:0] == OPT_PTR_SFR) begin
            optionPointer_r <= cpuReq.wdata;
        end
    end

    // External page; upper four bits are not stored
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            externalRamPage_r <= XPAGE_RST;
        end else if (cpuReq.wr && sfrSel && cpuReq.addr[7:0] == XPAGE_SFR) begin
            externalRamPage_r <= cpuReq.wdata[3:0];
        end
    end

    // Power-on load of option values after reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            optionLoaded_r <= 1'b0;
        end else begin
            optionLoaded_r <= 1'b1;
        end
    end

    // Trim register: factory value first, then software writes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oscillatorTrim_r <= 8'h00;
            factoryTrim_r    <= 8'h00;
        end else if (!optionLoaded_r) begin
            oscillatorTrim_r <= factoryTrimValue;
            factoryTrim_r    <= factoryTrimValue;
        end else if (optWrite && optionPointer_r == OPT_TRIM_IDX) begin
            oscillatorTrim_r <= cpuReq.wdata;
        end
    end

    // Boot area size and its base address move together
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bootAreaSize_r <= 2'h0;
            bootAreaBase_r <= FLASH_BYTES;
        end else if (!optionLoaded_r) begin
            bootAreaSize_r <= bootSizeStrap;
            bootAreaBase_r <= bootBase(bootSizeStrap);
        end else if (optWrite && optionPointer_r == OPT_BOOT_IDX) begin
            bootAreaSize_r <= cpuReq.wdata[1:0];
            bootAreaBase_r <= bootBase(cpuReq.wdata[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator estimate

    // Frequency follows the trim one cycle later
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oscFreqTenthKhz_r <= 20'h4E200;
            trimOverLimit_r   <= 1'b0;
        end else begin
            oscFreqTenthKhz_r <= freqOf(oscillatorTrim_r, factoryTrim_r);
            trimOverLimit_r   <= int'(freqOf(oscillatorTrim_r, factoryTrim_r)) > FREQ_LIMIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Selected option register; unknown indices read zero
    always_comb begin
        case (optionPointer_r)
            OPT_TRIM_IDX: optRdata = oscillatorTrim_r;
            OPT_BOOT_IDX: optRdata = {6'h00, bootAreaSize_r};
            default:      optRdata = 8'h00;
        endcase
    end

    // SFRs of this block; other SFR addresses read zero
    always_comb begin
        case (cpuReq.addr[7:0])
            XPAGE_SFR:   sfrRdata = {4'h0, externalRamPage_r};
            OPT_PTR_SFR: sfrRdata = optionPointer_r;
            OPT_VAL_SFR: sfrRdata = optRdata;
            default:     sfrRdata = 8'h00;
        endcase
    end

    // Answer mux
    always_comb begin
        rdNxt = 8'h00;
        if (sfrSel) begin
            rdNxt = sfrRdata;
        end else if (xSel) begin
            rdNxt = xRdata;
        end else if (iramSel && cpuReq.space == SPACE_BIT) begin
            rdNxt = {7'h00, |(iramRdata & iramMask)};
        end else if (iramSel) begin
            rdNxt = iramRdata;
        end
    end

    // Registered answer, one cycle after the read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuRsp_r <= '0;
        end else begin
            cpuRsp_r.valid <= cpuReq.rd;
            cpuRsp_r.rdata <= cpuReq.rd ? rdNxt : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence sIndWrRd;
        (cpuReq.wr && cpuReq.space == SPACE_INDIRECT)
        ##1 (cpuReq.rd && !cpuReq.wr && cpuReq.space == SPACE_INDIRECT
             && cpuReq.addr[7:0] == $past(cpuReq.addr[7:0]));
    endsequence

    sequence sTrimSel;
        (cpuReq.wr && cpuReq.space == SPACE_DIRECT && cpuReq.addr[7:0] == OPT_PTR_SFR
         && cpuReq.wdata == OPT_TRIM_IDX)
        ##1 (cpuReq.wr && cpuReq.space == SPACE_DIRECT
             && cpuReq.addr[7:0] == OPT_VAL_SFR && optionLoaded_r);
    endsequence

    AST_TRIM_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sTrimSel |=> oscillatorTrim_r == $past(cpuReq.wdata))
        else $error("trim not updated by option write");

    AST_POWER_ON: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(optionLoaded_r) |-> oscillatorTrim_r == $past(factoryTrimValue))
        else $error("trim not loaded with factory value");

    AST_FREQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        optionLoaded_r |=> oscFreqTenthKhz_r
            == freqOf($past(oscillatorTrim_r), $past(factoryTrim_r)))
        else $error("frequency estimate wrong");

    AST_BOOT_BASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        bootAreaSize_r == 2'b10 |-> bootAreaBase_r == FLASH_BYTES - BOOT_2K)
        else $error("boot base wrong for 2K");

    AST_IND_RAM: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sIndWrRd |=> cpuRsp_r.valid && cpuRsp_r.rdata == $past(cpuReq.wdata, 2))
        else $error("indirect RAM read-back wrong");

    AST_SFR_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cpuReq.rd && cpuReq.space == SPACE_DIRECT && cpuReq.addr[7:0] >= UPPER_LO
         && cpuReq.addr[7:0] < XPAGE_SFR)
        |=> cpuRsp_r.rdata == 8'h00)
        else $error("direct upper access reached RAM");

    AST_PAGE_RESV: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cpuReq.rd && cpuReq.space == SPACE_DIRECT && cpuReq.addr[7:0] == XPAGE_SFR)
        |=> cpuRsp_r.rdata[7:4] == 4'h0)
        else $error("page reserved bits not zero");

    AST_XHOLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cpuReq.rd && cpuReq.space == SPACE_XDPTR
         && cpuReq.addr > XRAM_HI && cpuReq.addr < PWM_LO)
        |=> cpuRsp_r.valid && cpuRsp_r.rdata == 8'h00)
        else $error("external hole not zero");

    AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(cpuReq.wr && sfrSel && cpuReq.addr[7:0] == OPT_PTR_SFR)
        |=> $stable(optionPointer_r))
        else $error("option pointer changed without write");

    AST_RSP_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cpuReq.rd |=> cpuRsp_r.valid ##1 (cpuRsp_r.valid == $past(cpuReq.rd)))
        else $error("answer valid timing wrong");

endmodule

//--- testbench/dsoa_cpu_model.sv
// CPU core model issuing data space requests to the block
`timescale 1ns/1ps
module dsoa_cpu_model
    import dsoa_pkg::*;
(
    input  wire dsoa_pkg::dsoa_rsp_t cpuRsp_r,
    input  wire logic                ref_clk,
    output dsoa_pkg::dsoa_req_t      cpuReq
);
    // Idle at time zero
    initial begin
        cpuReq = '0;
    end

    // One request held through its taking edge, then released with rd and wr cleared and address and data inverted
    task automatic access(input logic rd, input logic wr, input dsoa_space_t space,
                          input logic [15:0] addr, input logic [7:0] wdata,
                          output logic valid, output logic [7:0] rdata);
        int unsigned gap;
        gap = $urandom_range(2, 0);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        cpuReq <= '{rd: rd, wr: wr, space: space, addr: addr, wdata: wdata};
        @(posedge ref_clk);
        cpuReq <= '{rd: 1'b0, wr: 1'b0, space: space, addr: ~addr, wdata: ~wdata};
        #1;
        // Read answer was launched by the taking edge and stands until the next one
        valid = cpuRsp_r.valid;
        rdata = cpuRsp_r.rdata;
    endtask

    // Two requests on consecutive edges; returns the answer to the second one
    task automatic burst(input dsoa_req_t first, input dsoa_req_t second,
                         output logic valid, output logic [7:0] rdata);
        @(posedge ref_clk);
        cpuReq <= first;
        @(posedge ref_clk);
        cpuReq <= second;
        @(posedge ref_clk);
        cpuReq <= '{rd: 1'b0, wr: 1'b0, space: second.space, addr: ~second.addr,
                    wdata: ~second.wdata};
        #1;
        valid = cpuRsp_r.valid;
        rdata = cpuRsp_r.rdata;
    endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the data space and option access block
`timescale 1ns/1ps
module tb;
    import dsoa_pkg::*;
    logic        ref_clk;
    logic        rst_b;
    dsoa_req_t   cpuReq;
    logic [1:0]  bankSelect;
    logic [7:0]  factoryTrimValue;
    logic [1:0]  bootSizeStrap;
    dsoa_rsp_t   cpuRsp_r;
    logic [7:0]  oscillatorTrim_r;
    logic [1:0]  bootAreaSize_r;
    logic [16:0] bootAreaBase_r;
    logic [19:0] oscFreqTenthKhz_r;
    logic        trimOverLimit_r;
    logic        optionLoaded_r;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    dsoa_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .cpuReq(cpuReq), .bankSelect(bankSelect),
        .factoryTrimValue(factoryTrimValue), .bootSizeStrap(bootSizeStrap),
        .cpuRsp_r(cpuRsp_r), .oscillatorTrim_r(oscillatorTrim_r),
        .bootAreaSize_r(bootAreaSize_r), .bootAreaBase_r(bootAreaBase_r),
        .oscFreqTenthKhz_r(oscFreqTenthKhz_r), .trimOverLimit_r(trimOverLimit_r),
        .optionLoaded_r(optionLoaded_r));
    dsoa_cpu_model cpu (.cpuRsp_r(cpuRsp_r), .ref_clk(ref_clk), .cpuReq(cpuReq));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            summarize();
        end
    end

    // Verdict and end of run
    task automatic summarize();
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Expected boot area start per size code
    function automatic logic [16:0] expBase(input logic [1:0] s);
        case (s)
            2'b00: expBase = 17'h08000;
            2'b01: expBase = 17'h07C00;
            2'b10: expBase = 17'h07800;
            default: expBase = 17'h07000;
        endcase
    endfunction

    // Expected frequency estimate in 0.1 kHz
    function automatic int expFreq(input logic [7:0] t, input logic [7:0] f);
        expFreq = 320000 + 576 * (int'(t) - int'(f));
    endfunction

    task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic doWrite(input dsoa_space_t sp, input logic [15:0] a, input logic [7:0] d);
        logic       v;
        logic [7:0] r;
        cpu.access(1'b0, 1'b1, sp, a, d, v, r);
    endtask

    task automatic readCheck(input string name, input dsoa_space_t sp, input logic [15:0] a,
                             input logic [7:0] e);
        logic       v;
        logic [7:0] r;
        cpu.access(1'b1, 1'b0, sp, a, 8'h00, v, r);
        check({name, "_valid"}, 20'h1, {19'h0, v});
        check(name, {12'h0, e}, {12'h0, r});
    endtask

    // Trim through the option pointer and value port
    task automatic setTrim(input logic [7:0] v, input logic [7:0] fac);
        logic       bv;
        logic [7:0] br;
        // Pointer and value writes back to back
        cpu.burst('{1'b0, 1'b1, SPACE_DIRECT, 16'h00FE, OPT_TRIM_IDX},
                  '{1'b0, 1'b1, SPACE_DIRECT, 16'h00FF, v}, bv, br);
        check("trim", {12'h0, v}, {12'h0, oscillatorTrim_r});
        @(posedge ref_clk);
        #1;
        check("freq", 20'(expFreq(v, fac)), oscFreqTenthKhz_r);
        check("over", {19'h0, expFreq(v, fac) > 352000}, {19'h0, trimOverLimit_r});
        readCheck("trim_read", SPACE_DIRECT, 16'h00FF, v);
    endtask

    task automatic doReset(input logic [7:0] fac, input logic [1:0] strap);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        factoryTrimValue <= fac;
        bootSizeStrap <= strap;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("loaded", 20'h1, {19'h0, optionLoaded_r});
        check("trim_por", {12'h0, fac}, {12'h0, oscillatorTrim_r});
        check("size_por", {18'h0, strap}, {18'h0, bootAreaSize_r});
        check("base_por", {3'h0, expBase(strap)}, {3'h0, bootAreaBase_r});
        check("freq_por", 20'd320000, oscFreqTenthKhz_r);
        readCheck("ptr_por", SPACE_DIRECT, 16'h00FE, 8'h00);
        readCheck("page_por", SPACE_DIRECT, 16'h00F7, 8'h00);
    endtask

    // Main sequence
    initial begin
        logic [7:0]  fac;
        logic [7:0]  a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic [15:0] x;
        logic [3:0]  p;
        logic        b;
        int          seed;
        rst_b = 1'b0;
        bankSelect = 2'b00;
        factoryTrimValue = 8'h64;
        bootSizeStrap = 2'b00;
        seed = $urandom(97863);
        for (int k = 0; k < 2; k++) begin
            fac = 8'(60 + $urandom_range(89, 0));
            doReset(fac, 2'($urandom));
            if (k == 1) break;
            doWrite(SPACE_DIRECT, 16'h0081, 8'hE0);
            readCheck("sfr_other", SPACE_DIRECT, 16'h0081, 8'h00);
            setTrim(fac + 8'd55, fac);
            setTrim(fac + 8'd56, fac);
            repeat (6) setTrim(8'(int'(fac) + $urandom_range(100, 0) - 50), fac);
            doWrite(SPACE_DIRECT, 16'h00FE, OPT_BOOT_IDX);
            for (int s = 0; s < 4; s++) begin
                doWrite(SPACE_DIRECT, 16'h00FF, {6'h2A, 2'(s)});
                check("size", 20'(s), {18'h0, bootAreaSize_r});
                check("base", {3'h0, expBase(2'(s))}, {3'h0, bootAreaBase_r});
                readCheck("size_read", SPACE_DIRECT, 16'h00FF, {6'h0, 2'(s)});
            end
            doWrite(SPACE_INDIRECT, 16'h00FE, 8'h5A);
            readCheck("sfr_vs_ram", SPACE_DIRECT, 16'h00FE, OPT_BOOT_IDX);
            readCheck("upper_ram", SPACE_INDIRECT, 16'h00FE, 8'h5A);
            // Indirect write followed at once by an indirect read of the same byte
            cpu.burst('{1'b0, 1'b1, SPACE_INDIRECT, 16'h00C5, 8'hA7},
                      '{1'b1, 1'b0, SPACE_INDIRECT, 16'h00C5, 8'h00}, b, d);
            check("b2b_valid", 20'h1, {19'h0, b});
            check("b2b_ram", 20'h000A7, {12'h0, d});
            repeat (40) begin
                a = 8'($urandom);
                d = 8'($urandom);
                doWrite(a[7] ? SPACE_INDIRECT : SPACE_DIRECT, {8'h00, a}, d);
                readCheck("iram", SPACE_INDIRECT, {8'h00, a}, d);
            end
            for (int n = 0; n < 4; n++) begin
                @(posedge ref_clk);
                bankSelect <= 2'(n);
                a = 8'($urandom_range(7, 0));
                d = 8'($urandom);
                doWrite(SPACE_WREG, {8'h00, a}, d);
                readCheck("bank", SPACE_INDIRECT, 16'(n * 8) + {8'h00, a}, d);
            end
            repeat (16) begin
                a = 8'($urandom_range(127, 0));
                e = 8'($urandom);
                b = 1'($urandom);
                doWrite(SPACE_DIRECT, {8'h00, 8'h20 + {3'h0, a[7:3]}}, e);
                doWrite(SPACE_BIT, {8'h00, a}, {7'h0, b});
                e[a[2:0]] = b;
                readCheck("bit_byte", SPACE_DIRECT, {8'h00, 8'h20 + {3'h0, a[7:3]}}, e);
                readCheck("bit_sfr", SPACE_BIT, {8'h00, 8'h80 | a}, 8'h00);
            end
            doWrite(SPACE_DIRECT, 16'h0010, 8'hCC);
            doWrite(SPACE_XDPTR, 16'h0010, 8'h33);
            readCheck("x_vs_i", SPACE_DIRECT, 16'h0010, 8'hCC);
            repeat (30) begin
                x = 16'($urandom_range(4095, 0));
                d = 8'($urandom);
                doWrite(SPACE_XDPTR, x, d);
                readCheck("xram", SPACE_XDPTR, x, d);
            end
            doWrite(SPACE_DIRECT, 16'h00F7, 8'hFF);
            readCheck("page_rsv", SPACE_DIRECT, 16'h00F7, 8'h0F);
            repeat (8) begin
                p = 4'($urandom);
                a = 8'($urandom);
                d = 8'($urandom);
                doWrite(SPACE_DIRECT, 16'h00F7, {4'($urandom), p});
                doWrite(SPACE_XRI, {8'h00, a}, d);
                readCheck("xri_w", SPACE_XDPTR, {4'h0, p, a}, d);
                readCheck("xri_r", SPACE_XRI, {8'h00, a}, d);
            end
            for (int w = 16'h1034; w <= 16'h104F; w++) begin
                d = 8'($urandom);
                doWrite(SPACE_XDPTR, 16'(w), d);
                readCheck("pwm", SPACE_XDPTR, 16'(w), d);
            end
            doWrite(SPACE_XDPTR, 16'h1033, 8'h77);
            readCheck("hole_lo", SPACE_XDPTR, 16'h1033, 8'h00);
            doWrite(SPACE_XDPTR, 16'h1050, 8'h77);
            readCheck("hole_hi", SPACE_XDPTR, 16'h1050, 8'h00);
            readCheck("hole_mid", SPACE_XDPTR, 16'h1000, 8'h00);
        end
        summarize();
    end
endmodule
